// ==== src/scr_pkg.sv ====
package scr_pkg;

  // ==========================================================
  // Register offsets on the serial port
  localparam logic [14:0] OFS_PRIMARY_CONFIG = 15'h0000;
  localparam logic [14:0] OFS_SECONDARY_CONFIG = 15'h0001;
  localparam logic [14:0] OFS_POWER_MODE_CONFIG = 15'h0002;
  localparam logic [14:0] OFS_DEVICE_CLASS = 15'h0003;
  localparam logic [14:0] OFS_SILICON_REVISION = 15'h0006;
  localparam logic [14:0] OFS_MAKER_CODE_HI = 15'h000C;
  localparam logic [14:0] OFS_MAKER_CODE_LO = 15'h000D;
  localparam logic [14:0] OFS_USER_PORT_CONFIG = 15'h0010;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_PRIMARY_CONFIG = 8'h3C;
  localparam logic [7:0] RST_POWER_MODE_CONFIG = 8'h00;
  localparam logic [7:0] RST_USER_PORT_CONFIG = 8'h00;
  localparam logic [7:0] SECONDARY_CONFIG_VAL = 8'h00;

  // ==========================================================
  // Field positions
  localparam int SOFT_RESET_HI = 7;
  localparam int SOFT_RESET_LO = 0;
  localparam int STREAM_DIR_HI = 5;
  localparam int STREAM_DIR_LO = 2;
  localparam int POWER_MODE_MSB = 1;
  localparam int ADDR_HOLD_BIT = 0;

  // ==========================================================
  // Frame geometry; header and byte counts in serial clock edges
  localparam int ADDR_W = 15;
  localparam logic [4:0] HEADER_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [2:0] SYNC_STAGES = 3'h3;

  // Pins from the host, carried together through the synchroniser
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } scr_pins_s;

  // Frame sequencer
  typedef enum logic [1:0] {
    SCR_IDLE,
    SCR_HEADER,
    SCR_DATA
  } scr_state_e;

endpackage

// ==== src/scr_regs.sv ====
`timescale 1ns/1ps

module scr_regs
  import scr_pkg::*;
#(
  parameter logic [3:0] CLASS_CODE = 4'hA, // Arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h21, // Arbitrary value
  parameter logic [15:0] MAKER_CODE = 16'h5A5A // Arbitrary value
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  output logic power_down,
  output logic stream_dir,
  output logic addr_hold
);

  // ==========================================================
  // Helper functions

  // Low nibble must be the bit-reversed high nibble
  function automatic logic is_palindrome(input logic [7:0] d);
    is_palindrome = (d[0] == d[7]) && (d[1] == d[6]) && (d[2] == d[5]) && (d[3] == d[4]);
  endfunction

  // Next streaming address
  function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a,
                                                  input logic asc,
                                                  input logic hold);
    if (hold) begin
      step_addr = a;
    end else if (asc) begin
      step_addr = a + 15'h0001;
    end else begin
      step_addr = a - 15'h0001;
    end
  endfunction

  // ==========================================================
  // Pin synchroniser, three stages

  scr_pins_s pin1_ff, pin2_ff, pin3_ff;
  scr_pins_s pin_ff, pin_d_ff;
  scr_pins_s nxt_pin;

  // Take a new level once stages two and three agree
  always_comb begin
    nxt_pin = pin_ff;
    if (pin2_ff.sclk == pin3_ff.sclk) begin
      nxt_pin.sclk = pin3_ff.sclk;
    end
    if (pin2_ff.cs_n == pin3_ff.cs_n) begin
      nxt_pin.cs_n = pin3_ff.cs_n;
    end
    if (pin2_ff.sdi == pin3_ff.sdi) begin
      nxt_pin.sdi = pin3_ff.sdi;
    end
  end

  // Synchroniser registers; idle bus level at reset
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin1_ff <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
      pin2_ff <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
      pin3_ff <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
      pin_ff <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
      pin_d_ff <= '{sclk: 1'b0, cs_n: 1'b1, sdi: 1'b0};
    end else begin
      pin1_ff <= '{sclk: sclk, cs_n: cs_n, sdi: sdi};
      pin2_ff <= pin1_ff;
      pin3_ff <= pin2_ff;
      pin_ff <= nxt_pin;
      pin_d_ff <= pin_ff;
    end
  end

  logic sclk_rise, sclk_fall, cs_start, cs_active;

  // Edges of the filtered pins
  assign sclk_rise = pin_ff.sclk && !pin_d_ff.sclk;
  assign sclk_fall = !pin_ff.sclk && pin_d_ff.sclk;
  assign cs_start = !pin_ff.cs_n && pin_d_ff.cs_n;
  assign cs_active = !pin_ff.cs_n;

  // ==========================================================
  // Frame sequencer and shift registers

  scr_state_e state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [ADDR_W:0] shift_ff, nxt_shift;
  logic rd_ff, nxt_rd;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [7:0] tx_ff, nxt_tx;
  logic bnd_ff, nxt_bnd;
  logic wr_stb;
  logic [7:0] wr_data;

  // Register state
  logic [7:0] pcfg_ff, nxt_pcfg;
  logic [7:0] pmode_ff, nxt_pmode;
  logic [7:0] uport_ff, nxt_uport;

  // Read multiplexer
  logic [7:0] rd_data;
  always_comb begin
    unique case (addr_ff)
      OFS_PRIMARY_CONFIG: rd_data = pcfg_ff;
      OFS_SECONDARY_CONFIG: rd_data = SECONDARY_CONFIG_VAL;
      OFS_POWER_MODE_CONFIG: rd_data = pmode_ff;
      OFS_DEVICE_CLASS: rd_data = {4'h0, CLASS_CODE};
      OFS_SILICON_REVISION: rd_data = REVISION_CODE;
      OFS_MAKER_CODE_HI: rd_data = MAKER_CODE[15:8];
      OFS_MAKER_CODE_LO: rd_data = MAKER_CODE[7:0];
      OFS_USER_PORT_CONFIG: rd_data = uport_ff;
      default: rd_data = 8'h00;
    endcase
  end

  // Header of R/W bit plus address, then data bytes
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_rd = rd_ff;
    nxt_addr = addr_ff;
    nxt_tx = tx_ff;
    nxt_bnd = bnd_ff;
    wr_stb = 1'b0;
    wr_data = {shift_ff[6:0], pin_ff.sdi};
    if (!cs_active) begin
      nxt_state = SCR_IDLE;
      nxt_bnd = 1'b0;
    end else if (cs_start || state_ff == SCR_IDLE) begin
      nxt_state = SCR_HEADER;
      nxt_cnt = 5'h00;
      nxt_bnd = 1'b0;
    end else if (sclk_rise) begin
      nxt_shift = {shift_ff[ADDR_W-1:0], pin_ff.sdi};
      nxt_cnt = cnt_ff + 5'h01;
      unique case (state_ff)
        SCR_HEADER: begin
          if (nxt_cnt == HEADER_BITS) begin
            nxt_rd = shift_ff[ADDR_W-1];
            nxt_addr = {shift_ff[ADDR_W-2:0], pin_ff.sdi};
            nxt_state = SCR_DATA;
            nxt_cnt = 5'h00;
            nxt_bnd = 1'b1;
          end
        end
        SCR_DATA: begin
          if (nxt_cnt == BYTE_BITS) begin
            wr_stb = !rd_ff;
            nxt_addr = step_addr(addr_ff, pcfg_ff[STREAM_DIR_HI],
                                 uport_ff[ADDR_HOLD_BIT]);
            nxt_cnt = 5'h00;
            nxt_bnd = 1'b1;
          end
        end
        default: begin
          nxt_state = SCR_IDLE;
        end
      endcase
    end else if (sclk_fall && state_ff == SCR_DATA) begin
      // Load a fresh byte after each boundary, else shift out
      if (bnd_ff) begin
        nxt_tx = rd_data;
        nxt_bnd = 1'b0;
      end else begin
        nxt_tx = {tx_ff[6:0], 1'b0};
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_ff <= SCR_IDLE;
      cnt_ff <= 5'h00;
      shift_ff <= 16'h0000;
      rd_ff <= 1'b0;
      addr_ff <= 15'h0000;
      tx_ff <= 8'h00;
      bnd_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      rd_ff <= nxt_rd;
      addr_ff <= nxt_addr;
      tx_ff <= nxt_tx;
      bnd_ff <= nxt_bnd;
    end
  end

  // ==========================================================
  // Register writes and soft reset

  logic pcfg_ok;
  assign pcfg_ok = is_palindrome(wr_data);

  always_comb begin
    nxt_pcfg = pcfg_ff;
    nxt_pmode = pmode_ff;
    nxt_uport = uport_ff;
    if (wr_stb) begin
      unique case (addr_ff)
        OFS_PRIMARY_CONFIG: begin
          if (pcfg_ok && wr_data[SOFT_RESET_HI]) begin
            // Defaults everywhere; direction keeps the written value
            nxt_pcfg = RST_PRIMARY_CONFIG;
            nxt_pcfg[STREAM_DIR_HI] = wr_data[STREAM_DIR_HI];
            nxt_pcfg[STREAM_DIR_LO] = wr_data[STREAM_DIR_HI];
            nxt_pmode = RST_POWER_MODE_CONFIG;
            nxt_uport = RST_USER_PORT_CONFIG;
          end else if (pcfg_ok) begin
            nxt_pcfg = wr_data;
            nxt_pcfg[SOFT_RESET_HI] = 1'b0;
            nxt_pcfg[SOFT_RESET_LO] = 1'b0;
          end
        end
        OFS_POWER_MODE_CONFIG: nxt_pmode = wr_data;
        OFS_USER_PORT_CONFIG: nxt_uport = wr_data;
        default: begin
          nxt_pcfg = pcfg_ff;
        end
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pcfg_ff <= RST_PRIMARY_CONFIG;
      pmode_ff <= RST_POWER_MODE_CONFIG;
      uport_ff <= RST_USER_PORT_CONFIG;
    end else begin
      pcfg_ff <= nxt_pcfg;
      pmode_ff <= nxt_pmode;
      uport_ff <= nxt_uport;
    end
  end

  // ==========================================================
  // Outputs

  assign sdo = tx_ff[7];
  assign sdo_oe = cs_active && (state_ff == SCR_DATA) && rd_ff;
  // Codes 2 and 3 power down, 0 and 1 run; only the top bit decides
  assign power_down = pmode_ff[POWER_MODE_MSB];
  assign stream_dir = pcfg_ff[STREAM_DIR_HI];
  assign addr_hold = uport_ff[ADDR_HOLD_BIT];

endmodule

// ==== test/scr_regs_properties.sv ====
`timescale 1ns/1ps

// ==========
// Port checks of the config register block
module scr_regs_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic power_down,
  input wire logic stream_dir,
  input wire logic addr_hold
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Host deselected for a while
  sequence s_desel; cs_n [*8]; endsequence
  sequence s_quiet; (!cs_n && $stable(sclk)) [*8]; endsequence
  property p_rst_val; $fell(reset) |-> stream_dir && !addr_hold && !power_down; endproperty
  property p_pd_idle; s_desel |-> $stable(power_down); endproperty
  property p_dir_idle; s_desel |-> $stable(stream_dir); endproperty
  property p_hold_idle; s_desel |-> $stable(addr_hold); endproperty
  property p_oe_idle; s_desel |-> !sdo_oe; endproperty
  property p_oe_rise; $rose(sdo_oe) |-> !cs_n; endproperty
  property p_oe_drop; $rose(cs_n) |-> ##[1:8] !sdo_oe; endproperty
  property p_sdo_hold; s_quiet |-> $stable(sdo); endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset value");
  a_pd_idle: assert property (p_pd_idle) else $error("power moved idle");
  a_dir_idle: assert property (p_dir_idle) else $error("dir moved idle");
  a_hold_idle: assert property (p_hold_idle) else $error("hold moved idle");
  a_oe_idle: assert property (p_oe_idle) else $error("drive while idle");
  a_oe_rise: assert property (p_oe_rise) else $error("drive unselected");
  a_oe_drop: assert property (p_oe_drop) else $error("drive after end");
  a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved");
endmodule

bind scr_regs scr_regs_chk i_chk (.mclk, .reset, .sclk, .cs_n, .sdo, .sdo_oe, .power_down,
  .stream_dir, .addr_hold);

// ==== test/scr_host.sv ====
`timescale 1ns/1ps

// ==========
// Serial host on the control port
module scr_host (
  input wire logic mclk,
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  logic [7:0] wd [17];
  logic [7:0] rdat [17];
  // Idle pins
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // One clock level, long enough for the synchroniser
  task automatic half(input logic s);
    sclk = s;
    repeat (10) @(negedge mclk);
  endtask
  // Header then n whole bytes, MSB first
  task automatic frame(input logic rd, input logic [14:0] a, input int n);
    logic [15:0] h;
    h = {rd, a};
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = h[i];
      half(1'b0);
      half(1'b1);
    end
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) begin
        sdi = rd ? ~sdi : wd[k][i];
        half(1'b0);
        rdat[k][i] = sdo; // Taken at the rising edge
        half(1'b1);
      end
    end
    cs_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale bit
    half(1'b0);
  endtask
endmodule

// ==== test/tb_scr_regs.sv ====
`timescale 1ns/1ps

// ==========
// Bench with behavioural register model
module tb_scr_regs import scr_pkg::*;;
  localparam logic [3:0] CC = 4'h6; // Arbitrary value
  localparam logic [7:0] RV = 8'h2B; // Arbitrary value
  localparam logic [15:0] MK = 16'hC3E1; // Arbitrary value
  logic mclk, reset, sclk, cs_n, sdi, sdo, sdo_oe, power_down, stream_dir, addr_hold;
  logic sdo_line;
  logic [7:0] pri, pm, up, d;
  int fail_count, checks, cyc, seed;
  scr_regs #(.CLASS_CODE(CC), .REVISION_CODE(RV), .MAKER_CODE(MK)) i_dut (.mclk, .reset,
    .sclk, .cs_n, .sdi, .sdo, .sdo_oe, .power_down, .stream_dir, .addr_hold);
  // Undriven line shows the inverse, so a missing enable corrupts the read
  assign sdo_line = sdo_oe ? sdo : ~sdo;
  scr_host i_host (.mclk, .sclk, .cs_n, .sdi, .sdo(sdo_line));
  // Clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Model read
  function automatic logic [7:0] exp(input logic [14:0] a);
    case (a)
      15'h0000: exp = pri;
      15'h0002: exp = pm;
      15'h0003: exp = {4'h0, CC};
      15'h0006: exp = RV;
      15'h000C: exp = MK[15:8];
      15'h000D: exp = MK[7:0];
      15'h0010: exp = up;
      default: exp = 8'h00;
    endcase
  endfunction
  // Model write
  task automatic mwr(input logic [14:0] a, input logic [7:0] v);
    if (a == 15'h0000 && v[3:0] == {v[4], v[5], v[6], v[7]}) begin
      pri = {1'b0, v[6:1], 1'b0};
      if (v[7]) begin
        pri = {2'h0, v[5], 2'h3, v[5], 2'h0};
        pm = 8'h00;
        up = 8'h00;
      end
    end
    if (a == 15'h0002) pm = v;
    if (a == 15'h0010) up = v;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] want);
    checks++;
    if (got !== want) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // Stream n bytes from a, stepping like the device
  task automatic xfer(input logic rd, input logic [14:0] a, input int n);
    logic [14:0] p;
    logic [14:0] q;
    p = a;
    i_host.frame(rd, a, n);
    for (int k = 0; k < n; k++) begin
      // Step uses the settings in force before this byte lands
      q = up[0] ? p : (pri[5] ? p + 15'h0001 : p - 15'h0001);
      if (rd) cmp(i_host.rdat[k], exp(p));
      else mwr(p, i_host.wd[k]);
      p = q;
    end
    cmp({5'h0, power_down, addr_hold, stream_dir}, {5'h0, pm[1], up[0], pri[5]});
  endtask
  task automatic close_out();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    reset = 1'b1;
    seed = 33056;
    pri = 8'h3C;
    pm = 8'h00;
    up = 8'h00;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    xfer(1, 15'h0000, 17);
    $display("test reset_map done");
    for (int m = 0; m < 4; m++) begin
      i_host.wd[0] = {6'($random(seed)), m[1:0]};
      xfer(0, 15'h0002, 1);
      xfer(1, 15'h0002, 1);
    end
    $display("test power_mode done");
    d = 8'($random(seed));
    i_host.wd[0] = {d[7:4], ~d[4], d[5], d[6], d[7]};
    xfer(0, 15'h0000, 1);
    i_host.wd[0] = 8'h18;
    xfer(0, 15'h0000, 1);
    xfer(1, 15'h0001, 3);
    $display("test mirror_desc done");
    for (int k = 0; k < 11; k++) i_host.wd[k] = 8'($random(seed));
    xfer(0, 15'h000D, 11);
    xfer(1, 15'h000D, 12);
    $display("test read_only done");
    i_host.wd[0] = 8'h01;
    xfer(0, 15'h0010, 1);
    xfer(1, 15'h0006, 3);
    i_host.wd[0] = 8'h03;
    xfer(0, 15'h0002, 1);
    i_host.wd[0] = 8'h81;
    xfer(0, 15'h0000, 1);
    xfer(1, 15'h0000, 3);
    $display("test soft_reset done");
    i_host.wd[0] = 8'h3C;
    xfer(0, 15'h0000, 1);
    i_host.wd[1] = 8'h18;
    xfer(0, 15'h7FFF, 2);
    $display("test wrap_up done");
    // Hard reset mid-run returns the direction bit to ascending
    reset = 1'b1;
    pri = 8'h3C;
    pm = 8'h00;
    up = 8'h00;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    xfer(1, 15'h0000, 3);
    $display("test hard_reset done");
    close_out();
  end
endmodule
